//--- design/lld_pkg.sv
// Constants, types and pin bundles of the low latency dram pin controller
package lld_pkg;
  localparam int unsigned CORE_CLK_PERIOD_NS = 8;
  localparam int unsigned CK_DIV             = 4;
  localparam int unsigned REF_WINDOW_NS      = 32000000;
  localparam int unsigned REF_CMDS_TOTAL     = 131072;
  localparam int unsigned REF_INT_CYC        = REF_WINDOW_NS / (REF_CMDS_TOTAL * CORE_CLK_PERIOD_NS);
  localparam int unsigned REF_LATE_MAX       = 255;
  localparam int unsigned TRC_MIN_NS         = 15;
  localparam int unsigned TRC_MIN_CYC        = (TRC_MIN_NS + CORE_CLK_PERIOD_NS - 1) / CORE_CLK_PERIOD_NS;
  localparam int unsigned RD_TIMEOUT_CYC     = 1023;

  localparam int unsigned ADDR_W   = 22;
  localparam int unsigned BANK_W   = 3;
  localparam int unsigned DQ_W     = 36;
  localparam int unsigned HALF_W   = 18;
  localparam int unsigned BEAT_MAX = 8;
  localparam int unsigned BEAT_AW  = 3;
  localparam int unsigned TERM_ADDR_BIT = 9;

  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_ADDR = 5'h04;
  localparam logic [4:0] OFS_CFG  = 5'h08;
  localparam logic [4:0] OFS_STAT = 5'h0c;
  localparam logic [4:0] OFS_WDLO = 5'h10;
  localparam logic [4:0] OFS_WDHI = 5'h14;
  localparam logic [4:0] OFS_RDLO = 5'h18;
  localparam logic [4:0] OFS_RDHI = 5'h1c;

  localparam int unsigned CTRL_GO_BIT   = 0;
  localparam int unsigned CTRL_OP_LSB   = 1;
  localparam int unsigned CTRL_AREF_BIT = 3;
  localparam int unsigned CTRL_SEL_LSB  = 4;
  localparam int unsigned ADDR_BANK_LSB = 22;
  localparam int unsigned CFG_BL_LSB    = 0;
  localparam int unsigned CFG_DLY_LSB   = 2;
  localparam int unsigned CFG_TRC_LSB   = 6;
  localparam int unsigned CFG_TERM_BIT  = 10;
  localparam int unsigned CFG_MASK_LSB  = 11;

  localparam logic [31:0] CTRL_RMASK = 32'h0000_007e;
  localparam logic [31:0] ADDR_RMASK = 32'h01ff_ffff;
  localparam logic [31:0] CFG_RMASK  = 32'h0007_ffff;
  localparam logic [31:0] WDHI_RMASK = 32'h0000_000f;
  localparam logic [31:0] CTRL_RST   = 32'h0000_0008;
  localparam logic [31:0] CFG_RST    = 32'h0000_0111;

  // Pin levels {chip select, write, renew}, all active low
  localparam logic [2:0] PINS_READ   = 3'h3;
  localparam logic [2:0] PINS_WRITE  = 3'h1;
  localparam logic [2:0] PINS_REFR   = 3'h2;
  localparam logic [2:0] PINS_CONFIG = 3'h0;

  typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_REFRESH, OP_CONFIG} lld_op_e;

  typedef struct packed {
    logic                chip_sel_n;
    logic                write_cmd_n;
    logic                renew_cmd_n;
    logic [BANK_W-1:0]   internal_array_select;
    logic [ADDR_W-1:0]   addr_in;
  } lld_cmd_s;

  localparam lld_cmd_s CMD_NOP = '{chip_sel_n: 1'b1, write_cmd_n: 1'b1, renew_cmd_n: 1'b1,
                                   internal_array_select: 3'h0, addr_in: 22'h0};

  typedef struct packed {
    logic low_true;
    logic low_comp;
    logic high_true;
    logic high_comp;
  } lld_wclk_s;

  typedef struct packed {
    logic [DQ_W-1:0] dq;
    logic            dq_oe_n;
    logic            write_beat_mask;
  } lld_wdat_s;

  typedef struct packed {
    logic            read_echo_clk_first;
    logic            read_echo_clk_second;
    logic            rd_valid_flag;
    logic [DQ_W-1:0] dq;
  } lld_rpin_s;
endpackage

//--- design/lld_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/100ps
module lld_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rstn,
  input  wire logic         i_en,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      meta_q <= '0;
      o_q    <= '0;
    end
    else if (i_en)
    begin
      meta_q <= i_d;
      o_q    <= meta_q;
    end
  end
endmodule

//--- design/lld_beat_mem.sv
// Small beat store with registered read data
`timescale 1ns/100ps
module lld_beat_mem #(
  parameter int unsigned W  = 18,
  parameter int unsigned D  = 8,
  parameter int unsigned AW = 3
) (
  input  wire logic          i_clk,
  input  wire logic          i_rstn,
  input  wire logic          i_en,
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [W-1:0]  i_wdata,
  input  wire logic [AW-1:0] i_raddr,
  output logic      [W-1:0]  o_rdata
);
  logic [W-1:0] mem [D];

  always_ff @(posedge i_clk)
  begin
    if (i_en && i_we)
      mem[i_waddr] <= i_wdata;
  end

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      o_rdata <= '0;
    else if (i_en)
      o_rdata <= mem[i_raddr];
  end
endmodule

//--- design/lld_ctrl.sv
// Controller that drives the low latency dram pins under software command
//
// Register access over Avalon-MM and the register offsets were decided locally.
`timescale 1ns/100ps
module lld_ctrl
  import lld_pkg::*;
(
  input  wire logic        i_core_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_clk_en,
  input  wire logic [4:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  output lld_cmd_s         o_cmd,
  output logic             o_cmd_clk_true,
  output logic             o_cmd_clk_comp,
  output lld_wclk_s        o_wclk,
  output lld_wdat_s        o_wdat,
  input  wire lld_rpin_s   i_rpin
);
  typedef enum logic [2:0] {ST_IDLE, ST_ISSUE, ST_WLAT, ST_WDATA, ST_RWAIT} lld_state_e;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn || !i_clk_en);

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[8*i +: 8] = nw[8*i +: 8];
    return r;
  endfunction

  lld_state_e        state_q;
  lld_op_e           job_op_q;
  logic [1:0]        ph_q;
  logic [1:0]        ph_d;
  logic              ack_q;
  logic              acc;
  logic              wr_fire;
  logic [31:0]       ctrl_q;
  logic [31:0]       addr_q;
  logic [31:0]       cfg_q;
  logic [31:0]       wdlo_q;
  logic [31:0]       wdhi_q;
  logic [31:0]       rd_mux;
  logic              go;
  logic              req_q;
  logic              done_q;
  logic              rd_tmo_q;
  logic              busy;
  logic              tick;
  logic              issue;
  logic              taken;
  logic [BANK_W-1:0] cur_bank;
  logic [BANK_W-1:0] last_bank_q;
  logic [BANK_W-1:0] ref_bank_q;
  logic [5:0]        trc_cnt_q;
  logic [5:0]        trc_ld;
  logic [3:0]        beats;
  logic [4:0]        lat_q;
  logic [3:0]        beat_cnt_q;
  logic              wr_start;
  logic              wr_next;
  logic              wr_end;
  logic [3:0]        lo_cnt_q;
  logic [3:0]        hi_cnt_q;
  logic [9:0]        tmo_q;
  logic              rd_done;
  logic              rd_abort;
  logic [31:0]       ref_tmr_q;
  logic              ref_pend_q;
  logic [7:0]        ref_age_q;
  logic [$bits(lld_rpin_s)-1:0] rp_raw;
  lld_rpin_s         rp_s;
  logic              ekf_prev_q;
  logic              eks_prev_q;
  logic              cap_f_q;
  logic              cap_s_q;
  logic              lo_we;
  logic              hi_we;
  logic [HALF_W-1:0] mem_lo;
  logic [HALF_W-1:0] mem_hi;
  logic [5:0]        drv_cnt_q;
  logic [7:0]        gap_q;
  lld_cmd_s          new_cmd;

  wire logic [1:0]        cfg_bl   = cfg_q[CFG_BL_LSB +: 2];
  wire logic [3:0]        cfg_dly  = cfg_q[CFG_DLY_LSB +: 4];
  wire logic [3:0]        cfg_trc  = cfg_q[CFG_TRC_LSB +: 4];
  wire logic [7:0]        cfg_mask = cfg_q[CFG_MASK_LSB +: 8];
  wire logic              aref_en  = ctrl_q[CTRL_AREF_BIT];
  wire logic [BEAT_AW-1:0] rd_sel  = ctrl_q[CTRL_SEL_LSB +: BEAT_AW];

  // Avalon slave: one wait cycle, so registered memory data is always ready
  assign acc     = (i_avs_read | i_avs_write) & ~ack_q;
  assign wr_fire = i_avs_write & ack_q;
  assign go      = wr_fire && (i_avs_address == OFS_CTRL) && i_avs_byteenable[0]
                   && i_avs_writedata[CTRL_GO_BIT];

  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      ack_q             <= 1'b0;
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata    <= 32'h0;
    end
    else if (i_clk_en)
    begin
      ack_q             <= acc;
      o_avs_waitrequest <= ~acc;
      if (acc && i_avs_read)
        o_avs_readdata <= rd_mux;
    end
  end

  always_comb
  begin
    case (i_avs_address)
      OFS_CTRL: rd_mux = ctrl_q & CTRL_RMASK;
      OFS_ADDR: rd_mux = addr_q & ADDR_RMASK;
      OFS_CFG:  rd_mux = cfg_q & CFG_RMASK;
      OFS_STAT: rd_mux = {28'h0, ref_pend_q, rd_tmo_q, done_q, busy};
      OFS_WDLO: rd_mux = wdlo_q;
      OFS_WDHI: rd_mux = wdhi_q & WDHI_RMASK;
      OFS_RDLO: rd_mux = {mem_hi[13:0], mem_lo};
      OFS_RDHI: rd_mux = {28'h0, mem_hi[17:14]};
      default:  rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      ctrl_q <= CTRL_RST;
      addr_q <= 32'h0;
      cfg_q  <= CFG_RST;
      wdlo_q <= 32'h0;
      wdhi_q <= 32'h0;
    end
    else if (i_clk_en && wr_fire)
    begin
      case (i_avs_address)
        OFS_CTRL: ctrl_q <= be_merge(ctrl_q, i_avs_writedata, i_avs_byteenable) & CTRL_RMASK;
        OFS_ADDR: addr_q <= be_merge(addr_q, i_avs_writedata, i_avs_byteenable) & ADDR_RMASK;
        OFS_CFG:  cfg_q  <= be_merge(cfg_q, i_avs_writedata, i_avs_byteenable) & CFG_RMASK;
        OFS_WDLO: wdlo_q <= be_merge(wdlo_q, i_avs_writedata, i_avs_byteenable);
        OFS_WDHI: wdhi_q <= be_merge(wdhi_q, i_avs_writedata, i_avs_byteenable) & WDHI_RMASK;
        default:  ;
      endcase
    end
  end

  // Clock generation: CK spans four core cycles, strobes lag by one cycle
  assign ph_d = ph_q + 2'd1;
  assign tick = ph_q[0];

  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      ph_q           <= 2'd0;
      o_cmd_clk_true <= 1'b0;
      o_cmd_clk_comp <= 1'b1;
      o_wclk         <= '{low_true: 1'b1, low_comp: 1'b0, high_true: 1'b1, high_comp: 1'b0};
    end
    else if (i_clk_en)
    begin
      ph_q           <= ph_d;
      o_cmd_clk_true <= ph_d[1];
      o_cmd_clk_comp <= ~ph_d[1];
      o_wclk.low_true  <= ~(ph_d[1] ^ ph_d[0]);
      o_wclk.low_comp  <= ph_d[1] ^ ph_d[0];
      o_wclk.high_true <= ~(ph_d[1] ^ ph_d[0]);
      o_wclk.high_comp <= ph_d[1] ^ ph_d[0];
    end
  end

  // Software requests wait in req_q; a request while busy is dropped
  assign busy  = (state_q != ST_IDLE) | req_q;
  assign taken = (state_q == ST_IDLE) & (ref_pend_q | req_q);

  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      req_q    <= 1'b0;
      done_q   <= 1'b0;
      rd_tmo_q <= 1'b0;
    end
    else if (i_clk_en)
    begin
      if (go && !busy)
        req_q <= 1'b1;
      else if (taken && !ref_pend_q)
        req_q <= 1'b0;
      if (wr_end || rd_done || (issue && job_op_q == OP_CONFIG))
        done_q <= 1'b1;
      else if (go && !busy)
        done_q <= 1'b0;
      if (rd_abort)
        rd_tmo_q <= 1'b1;
      else if (go && !busy)
        rd_tmo_q <= 1'b0;
    end
  end

  // Refresh pacing; a pending refresh beats a software request
  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      ref_tmr_q  <= 32'h0;
      ref_pend_q <= 1'b0;
      ref_bank_q <= 3'h0;
      ref_age_q  <= 8'h0;
    end
    else if (i_clk_en)
    begin
      ref_tmr_q  <= (ref_tmr_q == 32'(REF_INT_CYC - 1)) ? 32'h0 : ref_tmr_q + 32'h1;
      if (aref_en && ref_tmr_q == 32'(REF_INT_CYC - 1))
        ref_pend_q <= 1'b1;
      else if (taken)
        ref_pend_q <= 1'b0;
      if (issue && job_op_q == OP_REFRESH)
        ref_bank_q <= ref_bank_q + 3'h1;
      if ((issue && job_op_q == OP_REFRESH) || !aref_en)
        ref_age_q <= 8'h0;
      else if (ref_age_q != 8'hff)
        ref_age_q <= ref_age_q + 8'h1;
    end
  end

  // Command issue, held across the CK rising edge
  assign cur_bank = (job_op_q == OP_REFRESH) ? ref_bank_q : addr_q[ADDR_BANK_LSB +: BANK_W];
  assign issue    = (state_q == ST_ISSUE) && (ph_q == 2'd3)
                    && !((cur_bank == last_bank_q) && (trc_cnt_q != 6'h0));
  assign trc_ld   = 6'(cfg_trc * CK_DIV);

  always_comb
  begin
    new_cmd = CMD_NOP;
    new_cmd.internal_array_select = cur_bank;
    new_cmd.addr_in = addr_q[ADDR_W-1:0];
    case (job_op_q)
      OP_READ:    {new_cmd.chip_sel_n, new_cmd.write_cmd_n, new_cmd.renew_cmd_n} = PINS_READ;
      OP_WRITE:   {new_cmd.chip_sel_n, new_cmd.write_cmd_n, new_cmd.renew_cmd_n} = PINS_WRITE;
      OP_REFRESH:
      begin
        {new_cmd.chip_sel_n, new_cmd.write_cmd_n, new_cmd.renew_cmd_n} = PINS_REFR;
        new_cmd.addr_in = 22'h0;
      end
      OP_CONFIG:
      begin
        {new_cmd.chip_sel_n, new_cmd.write_cmd_n, new_cmd.renew_cmd_n} = PINS_CONFIG;
        new_cmd.addr_in[TERM_ADDR_BIT] = cfg_q[CFG_TERM_BIT];
      end
      default:    new_cmd = CMD_NOP;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_cmd       <= CMD_NOP;
      trc_cnt_q   <= 6'h0;
      last_bank_q <= 3'h0;
    end
    else if (i_clk_en)
    begin
      if (ph_q == 2'd3)
        o_cmd <= issue ? new_cmd : CMD_NOP;
      if (issue)
      begin
        trc_cnt_q   <= (trc_ld < 6'(TRC_MIN_CYC)) ? 6'(TRC_MIN_CYC) : trc_ld;
        last_bank_q <= cur_bank;
      end
      else if (trc_cnt_q != 6'h0)
        trc_cnt_q <= trc_cnt_q - 6'h1;
    end
  end

  // Sequencer
  assign beats    = (cfg_bl == 2'd3) ? 4'd8 : 4'(4'd2 << cfg_bl);
  assign wr_start = (state_q == ST_WLAT) && tick && (lat_q == 5'h0);
  assign wr_next  = (state_q == ST_WDATA) && tick && (beat_cnt_q != beats);
  assign wr_end   = (state_q == ST_WDATA) && tick && (beat_cnt_q == beats);
  assign rd_done  = (state_q == ST_RWAIT) && (lo_cnt_q == beats) && (hi_cnt_q == beats);
  assign rd_abort = (state_q == ST_RWAIT) && !rd_done && (tmo_q == 10'(RD_TIMEOUT_CYC));

  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      state_q    <= ST_IDLE;
      job_op_q   <= OP_READ;
      lat_q      <= 5'h0;
      beat_cnt_q <= 4'h0;
      tmo_q      <= 10'h0;
    end
    else if (i_clk_en)
    begin
      case (state_q)
        ST_IDLE:
          if (taken)
          begin
            job_op_q <= ref_pend_q ? OP_REFRESH : lld_op_e'(ctrl_q[CTRL_OP_LSB +: 2]);
            state_q  <= ST_ISSUE;
          end
        ST_ISSUE:
          if (issue)
          begin
            lat_q <= {cfg_dly, 1'b0};
            tmo_q <= 10'h0;
            case (job_op_q)
              OP_WRITE: state_q <= ST_WLAT;
              OP_READ:  state_q <= ST_RWAIT;
              default:  state_q <= ST_IDLE;
            endcase
          end
        ST_WLAT:
          if (wr_start)
          begin
            beat_cnt_q <= 4'h1;
            state_q    <= ST_WDATA;
          end
          else if (tick)
            lat_q <= lat_q - 5'h1;
        ST_WDATA:
          if (wr_end)
            state_q <= ST_IDLE;
          else if (wr_next)
            beat_cnt_q <= beat_cnt_q + 4'h1;
        ST_RWAIT:
          if (rd_done || rd_abort)
            state_q <= ST_IDLE;
          else
            tmo_q <= tmo_q + 10'h1;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Write data changes on CK edges, so it sits centred on the strobe edges
  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      o_wdat <= '{dq: 36'h0, dq_oe_n: 1'b1, write_beat_mask: 1'b0};
    else if (i_clk_en)
    begin
      if (wr_start)
        o_wdat <= '{dq: {wdhi_q[3:0], wdlo_q}, dq_oe_n: 1'b0, write_beat_mask: cfg_mask[0]};
      else if (wr_next)
        o_wdat.write_beat_mask <= cfg_mask[beat_cnt_q[BEAT_AW-1:0]];
      else if (wr_end)
        o_wdat <= '{dq: 36'h0, dq_oe_n: 1'b1, write_beat_mask: 1'b0};
    end
  end

  // Read capture: echo clocks are slow pins, so data is taken one cycle after the edge
  lld_sync #(
    .W ($bits(lld_rpin_s))
  ) u_sync (
    .i_clk  (i_core_clk),
    .i_rstn (i_rstn),
    .i_en   (i_clk_en),
    .i_d    (i_rpin),
    .o_q    (rp_raw)
  );
  assign rp_s  = lld_rpin_s'(rp_raw);
  assign lo_we = cap_f_q && rp_s.rd_valid_flag && (state_q == ST_RWAIT) && (lo_cnt_q < beats);
  assign hi_we = cap_s_q && rp_s.rd_valid_flag && (state_q == ST_RWAIT) && (hi_cnt_q < beats);

  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      ekf_prev_q <= 1'b0;
      eks_prev_q <= 1'b0;
      cap_f_q    <= 1'b0;
      cap_s_q    <= 1'b0;
      lo_cnt_q   <= 4'h0;
      hi_cnt_q   <= 4'h0;
    end
    else if (i_clk_en)
    begin
      ekf_prev_q <= rp_s.read_echo_clk_first;
      eks_prev_q <= rp_s.read_echo_clk_second;
      cap_f_q    <= rp_s.read_echo_clk_first ^ ekf_prev_q;
      cap_s_q    <= rp_s.read_echo_clk_second ^ eks_prev_q;
      if (issue)
      begin
        lo_cnt_q <= 4'h0;
        hi_cnt_q <= 4'h0;
      end
      else
      begin
        if (lo_we)
          lo_cnt_q <= lo_cnt_q + 4'h1;
        if (hi_we)
          hi_cnt_q <= hi_cnt_q + 4'h1;
      end
    end
  end

  lld_beat_mem #(
    .W  (HALF_W),
    .D  (BEAT_MAX),
    .AW (BEAT_AW)
  ) u_mem_lo (
    .i_clk   (i_core_clk),
    .i_rstn  (i_rstn),
    .i_en    (i_clk_en),
    .i_we    (lo_we),
    .i_waddr (lo_cnt_q[BEAT_AW-1:0]),
    .i_wdata (rp_s.dq[HALF_W-1:0]),
    .i_raddr (rd_sel),
    .o_rdata (mem_lo)
  );

  lld_beat_mem #(
    .W  (HALF_W),
    .D  (BEAT_MAX),
    .AW (BEAT_AW)
  ) u_mem_hi (
    .i_clk   (i_core_clk),
    .i_rstn  (i_rstn),
    .i_en    (i_clk_en),
    .i_we    (hi_we),
    .i_waddr (hi_cnt_q[BEAT_AW-1:0]),
    .i_wdata (rp_s.dq[DQ_W-1:HALF_W]),
    .i_raddr (rd_sel),
    .o_rdata (mem_hi)
  );

  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      drv_cnt_q <= 6'h0;
    else if (i_clk_en)
      drv_cnt_q <= o_wdat.dq_oe_n ? 6'h0 : drv_cnt_q + 6'h1;
  end

  // Age since last issue, kept apart from the row cycle counter
  always_ff @(posedge i_core_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      gap_q <= 8'hff;
    else if (i_clk_en)
      gap_q <= issue ? 8'h0 : ((gap_q == 8'hff) ? gap_q : gap_q + 8'h1);
  end

  a_cmd_at_fall:
    assert property ($changed(o_cmd) |-> $fell(o_cmd_clk_true))
      else $error("Command pins changed away from a falling clock edge");

  a_cmd_hold_rise:
    assert property ($rose(o_cmd_clk_true) |-> $stable(o_cmd) ##1 $stable(o_cmd))
      else $error("Command or bank moved around the capturing edge");

  a_strobe_pairs:
    assert property (o_wclk.low_true == o_wclk.high_true && o_wclk.low_comp == !o_wclk.low_true
                     && o_wclk.high_comp == !o_wclk.high_true)
      else $error("Write strobe pairs disagree");

  a_strobe_runs:
    assert property ($rose(o_wclk.low_true) |-> ##4 $rose(o_wclk.low_true))
      else $error("Write strobe stopped toggling");

  a_data_centred:
    assert property ($changed(o_wdat.dq) |-> $changed(o_cmd_clk_true) && $stable(o_wclk.low_true))
      else $error("Write data moved on a strobe edge");

  a_mask_in_burst:
    assert property (o_wdat.write_beat_mask |-> !o_wdat.dq_oe_n
                     && ($stable(o_wdat.write_beat_mask) || $stable(o_wclk.high_true)))
      else $error("Mask asserted outside a write burst");

  a_burst_length:
    assert property ($rose(o_wdat.dq_oe_n) |-> drv_cnt_q == {1'b0, beats, 1'b0})
      else $error("Write burst length differs from configured beats");

  a_refresh_due:
    assert property (aref_en |-> ref_age_q < 8'(REF_LATE_MAX))
      else $error("Refresh overdue");

  a_bank_gap:
    assert property (issue && cur_bank == last_bank_q |-> gap_q >= 8'(TRC_MIN_CYC) && gap_q >= 8'(cfg_trc * CK_DIV))
      else $error("Same bank reused inside row cycle");

  a_config_term:
    assert property ($changed(o_cmd) && {o_cmd.chip_sel_n, o_cmd.write_cmd_n, o_cmd.renew_cmd_n} == PINS_CONFIG
                     |-> o_cmd.addr_in[TERM_ADDR_BIT] == cfg_q[CFG_TERM_BIT])
      else $error("Termination bit wrong on config load");
endmodule

//--- tb/lld_dev_model.sv
// Behavioural memory device answering the pin controller
`timescale 1ns/100ps
module lld_dev_model
  import lld_pkg::*;
#(
  parameter int BEATS = 4
) (
  input  wire lld_cmd_s  i_cmd,
  input  wire logic      i_ck,
  input  wire lld_wclk_s i_wclk,
  input  wire lld_wdat_s i_wdat,
  output lld_rpin_s      o_rpin
);
  logic [DQ_W-1:0]   mem [8];
  logic [BANK_W-1:0] bank;
  logic              echo = 1'b0;
  int                asked = 0;
  int                served = 0;
  initial o_rpin = '0;
  // Free running, so a stalled echo never hides a capture fault
  always #62.5 echo = ~echo;
  always @(posedge i_ck)
    if (i_cmd.chip_sel_n == 1'b0 && i_cmd.renew_cmd_n == 1'b1)
    begin
      bank <= i_cmd.internal_array_select;
      asked <= asked + (i_cmd.write_cmd_n ? BEATS : 0);
    end
  always @(i_wclk.high_true)
    if (i_wdat.dq_oe_n == 1'b0 && i_wdat.write_beat_mask == 1'b0)
      mem[bank] <= i_wdat.dq;
  // Idle data toggles so a late capture cannot pass by luck
  always @(echo)
  begin
    o_rpin.read_echo_clk_first <= echo;
    o_rpin.read_echo_clk_second <= echo;
    o_rpin.rd_valid_flag <= served < asked;
    o_rpin.dq <= served < asked ? mem[bank] : ~o_rpin.dq;
    served <= served + int'(served < asked);
  end
endmodule

//--- tb/test_lld_ctrl.sv
// Self-checking bench for the dram pin controller
`timescale 1ns/100ps
module test_lld_ctrl
  import lld_pkg::*;
;
  logic        clk;
  logic        rstn = 1'b0;
  logic [4:0]  adr = 5'h0;
  logic        rd_en = 1'b0;
  logic        wr_en = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic        wait_req;
  logic        ck;
  logic        ck_n;
  lld_cmd_s    cmd;
  lld_cmd_s    last;
  lld_wclk_s   wclk;
  lld_wdat_s   wdat;
  lld_rpin_s   rpin;
  int          ref_cnt = 0;
  int          err_count = 0;
  int          n_tests = 0;
  lld_ctrl uut (.i_core_clk(clk), .i_rstn(rstn), .i_clk_en(1'b1), .i_avs_address(adr), .i_avs_read(rd_en),
    .i_avs_write(wr_en), .i_avs_writedata(wdata), .i_avs_byteenable(4'hf), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wait_req), .o_cmd(cmd), .o_cmd_clk_true(ck), .o_cmd_clk_comp(ck_n), .o_wclk(wclk),
    .o_wdat(wdat), .i_rpin(rpin));
  lld_dev_model dev (.i_cmd(cmd), .i_ck(ck), .i_wclk(wclk), .i_wdat(wdat), .o_rpin(rpin));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge ck)
    if (cmd.chip_sel_n === 1'b0)
    begin
      last <= cmd;
      ref_cnt <= ref_cnt + int'(cmd.renew_cmd_n === 1'b0 && cmd.write_cmd_n === 1'b1);
    end
  always @(posedge clk)
    if (rstn)
      chk("cmd clk pair", 36'(ck_n), {35'h0, ~ck});
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [35:0] got, input logic [35:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    adr <= a;
    wdata <= d;
    wr_en <= wr;
    rd_en <= !wr;
    do @(posedge clk); while (wait_req !== 1'b0);
    q = rdata;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic run_op(input logic [1:0] op);
    logic [31:0] s;
    wr(OFS_CTRL, {29'h0, op, 1'b1});
    s = 32'h0;
    while (s[1] !== 1'b1)
      bus(1'b0, OFS_STAT, 32'h0, s);
  endtask
  task automatic read_back(input logic [35:0] exp);
    logic [31:0] lo;
    logic [31:0] hi;
    run_op(2'h0);
    chk("read pins", 36'({last.chip_sel_n, last.write_cmd_n, last.renew_cmd_n}), 36'(PINS_READ));
    // Last beat of the four-beat burst
    wr(OFS_CTRL, 32'h30);
    bus(1'b0, OFS_RDLO, 32'h0, lo);
    bus(1'b0, OFS_RDHI, 32'h0, hi);
    chk("read beat", {hi[3:0], lo}, exp);
  endtask
  task automatic t_reset();
    logic [31:0] q;
    bus(1'b0, OFS_CFG, 32'h0, q);
    chk("cfg reset", 36'(q), 36'(CFG_RST));
    bus(1'b0, 5'h02, 32'h0, q);
    chk("unmapped", 36'(q), 36'h0);
    repeat (100) @(posedge clk);
    chk("refresh issued", 36'(ref_cnt >= 2), 36'h1);
    wr(OFS_CTRL, 32'h0);
    repeat (40) @(posedge clk);
  endtask
  task automatic t_wr_rd();
    wr(OFS_ADDR, 32'h0140_0155);
    wr(OFS_WDLO, 32'h89ab_cdef);
    wr(OFS_WDHI, 32'h5);
    run_op(2'h1);
    chk("write pins", 36'({last.chip_sel_n, last.write_cmd_n, last.renew_cmd_n}), 36'(PINS_WRITE));
    chk("write bank", 36'(last.internal_array_select), 36'h5);
    chk("write addr", 36'(last.addr_in), 36'h155);
    read_back(36'h5_89ab_cdef);
    // Every beat masked: the stored word must survive
    wr(OFS_CFG, CFG_RST | 32'h0007_f800);
    wr(OFS_WDLO, 32'h0);
    wr(OFS_WDHI, 32'h0);
    run_op(2'h1);
    wr(OFS_CFG, CFG_RST);
    read_back(36'h5_89ab_cdef);
  endtask
  task automatic t_config();
    for (int t = 0; t < 2; t++)
    begin
      wr(OFS_CFG, CFG_RST | (32'(t) << CFG_TERM_BIT));
      run_op(2'h3);
      chk("config pins", 36'({last.chip_sel_n, last.write_cmd_n, last.renew_cmd_n}), 36'(PINS_CONFIG));
      chk("termination", 36'(last.addr_in[TERM_ADDR_BIT]), 36'(t));
    end
  endtask
  task automatic t_refresh();
    int          n0;
    logic [31:0] s;
    n0 = ref_cnt;
    wr(OFS_CTRL, 32'h5);
    s = 32'h1;
    while (s[0] !== 1'b0)
      bus(1'b0, OFS_STAT, 32'h0, s);
    repeat (4) @(posedge clk);
    chk("sw refresh", 36'(ref_cnt - n0), 36'h1);
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_wr_rd();
    t_config();
    t_refresh();
    complete_run();
  end
  initial
  begin
    #400000;
    err_count++;
    complete_run();
  end
endmodule
